// file: tb_top.sv
// Self-checking bench for the OUT endpoint block: AHB-Lite master, host model, result queues.
// Assumes the register map of uom_map.svh and the handshake codes of uom_pkg.
`timescale 1ns/1ps
`include "uom_map.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
   localparam logic [31:0] A_CSR = 32'h50, A_CFG = 32'h54, A_CNL = 32'h58, A_CNH = 32'h5C;
   localparam logic [31:0] A_SEL = 32'h38, A_DAT = 32'h80;
   logic clk, sys_rst, hsel, hwrite, hreadyout, hresp, rx_token, rx_valid, rx_ready, rx_end;
   logic rx_crc_err, rx_toggle, hs_valid;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, rx_ep, hs_code;
   logic [2:0] hsize, ep_event;
   logic [7:0] rx_data;
   logic [31:0] exp_rd[$];
   logic [1:0] exp_hs[$];
   logic [31:0] e_rd;
   logic [1:0] e_hs;
   int miscompares = 0, cmp_count = 0, ev_cnt[3] = '{0, 0, 0};
   int n1, na, nb, nc, i;
   logic [7:0] b1, ba, bb, bc;
   logic rd_dp = 1'b0;
   integer seed = 32'hB0D3;
   uom_out_ep dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_token(rx_token),
      .rx_ep(rx_ep), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
      .rx_end(rx_end), .rx_crc_err(rx_crc_err), .rx_toggle(rx_toggle), .hs_valid(hs_valid),
      .hs_code(hs_code), .ep_event(ep_event));
   uom_host host (.clk(clk), .rx_token(rx_token), .rx_ep(rx_ep), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_ready(rx_ready), .rx_end(rx_end), .rx_crc_err(rx_crc_err));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task complete_run();
      if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic wait_ready();
      int n;
      begin
         n = 0;
         do begin
            @(negedge clk);
            n++;
         end while (hreadyout !== 1'b1 && n < 64);
         if (n >= 64) begin
            miscompares++;
            complete_run();
         end
      end
   endtask
   // Single AHB-Lite word transfer; the upper data bytes carry noise the block must ignore.
   task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] d);
      logic [31:0] r;
      begin
         r = $random(seed);
         hsel <= 1'b1;
         haddr <= a;
         htrans <= 2'b10;
         hwrite <= wr;
         hsize <= 3'b010;
         wait_ready();
         @(posedge clk);
         hsel <= 1'b0;
         htrans <= 2'b00;
         hwdata <= {r[31:8], d};
         rd_dp = !wr;
         wait_ready();
         @(posedge clk);
         rd_dp = 1'b0;
      end
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      exp_rd.push_back(e);
      bus(1'b0, a, 8'h00);
   endtask
   task automatic settle();
      repeat (4) @(posedge clk);
   endtask
   task automatic pkt(input logic [1:0] ep, input int n, input logic [7:0] b, input logic crc,
                      input logic slow, input int hs);
      if (hs >= 0) exp_hs.push_back(2'(hs));
      host.send(ep, n, b, crc, slow);
      settle();
   endtask
   always @(negedge clk) begin
      if (rd_dp && hreadyout === 1'b1) begin
         e_rd = exp_rd.pop_front();
         `CHK("hrdata", e_rd, hrdata)
         `CHK("hresp", 1'b0, hresp)
      end
      if (hs_valid === 1'b1) begin
         e_hs = (exp_hs.size() > 0) ? exp_hs.pop_front() : 2'b00;
         `CHK("hs_code", e_hs, hs_code)
      end
      for (int k = 0; k < 3; k++) if (ep_event[k] === 1'b1) ev_cnt[k]++;
   end
   initial begin
      sys_rst = 1'b1;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'b010;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(32'h0000_000C, 32'h0);
      bus(1'b1, A_CSR, 8'h20);
      for (int ep = 1; ep <= 3; ep++) begin
         bus(1'b1, A_SEL, 8'(ep));
         for (int r = 0; r < 4; r++) rd(A_CSR + 32'(4 * r), 32'h0);
      end
      bus(1'b1, A_SEL, 8'h01);
      bus(1'b1, A_CFG, 8'hFF);
      bus(1'b1, A_CNH, 8'hFF);
      rd(A_CNH, 32'h0);
      bus(1'b1, A_SEL, 8'h02);
      rd(A_CFG, 32'h0);
      bus(1'b1, A_SEL, 8'h01);
      rd(A_CFG, 32'hC0);
      bus(1'b1, A_CFG, 8'h00);
      n1 = 1 + ($unsigned($random(seed)) % 8);
      b1 = 8'($random(seed));
      pkt(2'd1, n1, b1, 1'b0, 1'b1, uom_pkg::HS_ACK);
      rd(A_CSR, 32'h03);
      rd(A_CNL, 32'(n1));
      rd(A_CNH, 32'h0);
      pkt(2'd1, 3, 8'h5A, 1'b0, 1'b0, uom_pkg::HS_NAK);
      for (i = 0; i < n1; i++) rd(A_DAT, 32'(b1 + 8'(i)));
      @(negedge clk);
      `CHK("toggle", 1'b1, rx_toggle)
      @(posedge clk);
      bus(1'b1, A_CSR, 8'h80);
      @(negedge clk);
      `CHK("toggle", 1'b0, rx_toggle)
      @(posedge clk);
      rd(A_CSR, 32'h00);
      `CHK("ev1", 1, ev_cnt[0])
      bus(1'b1, A_SEL, 8'h02);
      bus(1'b1, A_CFG, 8'h80);
      rd(A_CFG, 32'h80);
      na = 1 + ($unsigned($random(seed)) % 8);
      nb = 1 + ($unsigned($random(seed)) % 8);
      nc = 1 + ($unsigned($random(seed)) % 8);
      ba = 8'($random(seed));
      bb = 8'($random(seed));
      bc = 8'($random(seed));
      pkt(2'd2, na, ba, 1'b0, 1'b0, uom_pkg::HS_ACK);
      pkt(2'd2, nb, bb, 1'b0, 1'b1, uom_pkg::HS_ACK);
      rd(A_CSR, 32'h03);
      rd(A_CNL, 32'(na));
      for (i = 0; i < na; i++) rd(A_DAT, 32'(ba + 8'(i)));
      bus(1'b1, A_CSR, 8'h00);
      rd(A_CSR, 32'h01);
      rd(A_CNL, 32'(nb));
      bus(1'b1, A_CSR, 8'h10);
      repeat (nb + 8) @(posedge clk);
      rd(A_CSR, 32'h00);
      pkt(2'd2, nc, bc, 1'b0, 1'b0, uom_pkg::HS_ACK);
      rd(A_CNL, 32'(nc));
      for (i = 0; i < nc; i++) rd(A_DAT, 32'(bc + 8'(i)));
      `CHK("ev2", 3, ev_cnt[1])
      bus(1'b1, A_CSR, 8'h00);
      bus(1'b1, A_CFG, 8'h00);
      bus(1'b1, A_SEL, 8'h03);
      bus(1'b1, A_CSR, 8'h20);
      pkt(2'd3, 2, 8'h11, 1'b0, 1'b0, uom_pkg::HS_STALL);
      pkt(2'd3, 2, 8'h22, 1'b0, 1'b1, uom_pkg::HS_STALL);
      rd(A_CSR, 32'h60);
      `CHK("ev3", 2, ev_cnt[2])
      bus(1'b1, A_CSR, 8'h20);
      rd(A_CSR, 32'h20);
      bus(1'b1, A_CFG, 8'h40);
      pkt(2'd3, 4, 8'h33, 1'b1, 1'b0, -1);
      rd(A_CSR, 32'h2B);
      rd(A_CNL, 32'h4);
      pkt(2'd3, 2, 8'h44, 1'b0, 1'b0, -1);
      rd(A_CSR, 32'h2F);
      `CHK("ev3", 4, ev_cnt[2])
      bus(1'b1, A_CSR, 8'h24);
      rd(A_CSR, 32'h24);
      bus(1'b1, A_CSR, 8'h00);
      rd(A_CSR, 32'h00);
      bus(1'b1, A_CFG, 8'hC0);
      bus(1'b1, A_CSR, 8'h20);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(A_SEL, 32'h0);
      bus(1'b1, A_SEL, 8'h03);
      rd(A_CFG, 32'h0);
      rd(A_CSR, 32'h0);
      rd(A_CNL, 32'h0);
      `CHK("rd_left", 0, exp_rd.size())
      `CHK("hs_left", 0, exp_hs.size())
      `CHK("host_tmo", 0, host.tmo)
      complete_run();
   end
   initial begin
      #400000;
      miscompares++;
      complete_run();
   end
endmodule

// file: uom_fifo.sv
// Byte FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module uom_fifo #(
   parameter int W = 8,
   parameter int D = 32
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0] wp_reg;
   logic [AW:0] rp_reg;
   wire [AW:0] used = wp_reg - rp_reg;
   wire do_in = in_valid & in_ready;
   wire do_out = out_valid & out_ready;
   assign in_ready = used != (AW + 1)'(D);
   assign out_valid = used != '0;
   assign out_data = mem[rp_reg[AW-1:0]];
   always_ff @(posedge clk) begin
      if (do_in) begin
         mem[wp_reg[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wp_reg <= '0;
         rp_reg <= '0;
      end else begin
         wp_reg <= wp_reg + (AW + 1)'(do_in);
         rp_reg <= rp_reg + (AW + 1)'(do_out);
      end
   end
endmodule

// file: uom_host.sv
// Behavioural USB host that sends OUT tokens, data bytes and packet ends.
// Assumes the caller starts each transfer just after a rising edge of clk.
`timescale 1ns/1ps
module uom_host (
   input wire logic clk,
   output logic rx_token,
   output logic [1:0] rx_ep,
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic rx_ready,
   output logic rx_end,
   output logic rx_crc_err
);
   int tmo;
   initial begin
      rx_token = 1'b0;
      rx_ep = 2'h0;
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_end = 1'b0;
      rx_crc_err = 1'b0;
      tmo = 0;
   end
   // One packet: token, bytes base+i (with idle gaps when slow), then a separate end cycle.
   task automatic send(input logic [1:0] ep, input int n, input logic [7:0] base,
                       input logic crc, input logic slow);
      int i;
      int w;
      begin
         rx_token <= 1'b1;
         rx_ep <= ep;
         @(posedge clk);
         rx_token <= 1'b0;
         rx_ep <= ~ep;
         for (i = 0; i < n; i++) begin
            if (slow) begin
               rx_valid <= 1'b0;
               rx_data <= ~rx_data;
               @(posedge clk);
            end
            rx_valid <= 1'b1;
            rx_data <= base + 8'(i);
            w = 0;
            do begin
               @(negedge clk);
               w++;
            end while (rx_ready !== 1'b1 && w < 100);
            if (w >= 100) tmo++;
            @(posedge clk);
         end
         // A released data line shows the inverse of its value one cycle before, so the end cycle shows the last byte again.
         rx_valid <= 1'b0;
         rx_data <= ~rx_data;
         @(posedge clk);
         rx_end <= 1'b1;
         rx_crc_err <= crc;
         rx_data <= ~rx_data;
         @(posedge clk);
         rx_end <= 1'b0;
         rx_crc_err <= 1'b0;
      end
   endtask
endmodule

// file: uom_map.svh
// Register indices, field positions and sizes of the OUT endpoint block.
// Byte address of a register is four times its index on a 32-bit bus.
`ifndef UOM_MAP_SVH
`define UOM_MAP_SVH
`define UOM_IDX_CSRL 6'h14
`define UOM_IDX_CFG 6'h15
`define UOM_IDX_CNTL 6'h16
`define UOM_IDX_CNTH 6'h17
`define UOM_IDX_EPSEL 6'h0E
`define UOM_IDX_DATA 6'h20
`define UOM_B_CLR_TOG 7
`define UOM_B_STL_SENT 6
`define UOM_B_SEND_STL 5
`define UOM_B_FLUSH 4
`define UOM_B_DERR 3
`define UOM_B_OVR 2
`define UOM_B_FULL 1
`define UOM_B_RDY 0
`define UOM_B_DBUF 7
`define UOM_B_ISO 6
`define UOM_EP_N 3
`define UOM_FIFO_W 8
`define UOM_FIFO_D 32
`define UOM_CNT_W 10
`endif

// file: uom_out_ep.sv
// OUT endpoint control and status for endpoints 1 to 3, registers on AHB-Lite.
// Assumes the link logic gives tokens, bytes and packet ends synchronous to clk.
`timescale 1ns/1ps
`include "uom_map.svh"
module uom_out_ep (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic rx_token,
   input wire logic [1:0] rx_ep,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic rx_ready,
   input wire logic rx_end,
   input wire logic rx_crc_err,
   output logic rx_toggle,
   output logic hs_valid,
   output logic [1:0] hs_code,
   output logic [2:0] ep_event
);
   localparam int FL_MAX = 40;

   logic [1:0] idx_reg;
   logic ph_wr_reg;
   logic ph_rd_reg;
   logic rd_done_reg;
   logic [5:0] ph_idx_reg;
   logic [31:0] hrdata_reg;
   uom_pkg::uom_rx_e st_reg;
   logic [1:0] rx_ep_reg;
   logic rx_iso_reg;
   logic rx_nak_reg;
   logic [9:0] rx_cnt_reg;
   logic hs_valid_reg;
   uom_pkg::uom_hs_e hs_code_reg;
   logic fl_busy_reg;
   logic [1:0] fl_ep_reg;
   logic [9:0] fl_left_reg;
   logic send_stall_reg [`UOM_EP_N];
   logic stall_sent_reg [`UOM_EP_N];
   logic ovr_reg [`UOM_EP_N];
   logic rdy_reg [`UOM_EP_N];
   logic dbuf_reg [`UOM_EP_N];
   logic iso_reg [`UOM_EP_N];
   logic tog_reg [`UOM_EP_N];
   logic err0_reg [`UOM_EP_N];
   logic err1_reg [`UOM_EP_N];
   logic ev_reg [`UOM_EP_N];
   logic [1:0] pnum_reg [`UOM_EP_N];
   logic [9:0] cnt0_reg [`UOM_EP_N];
   logic [9:0] cnt1_reg [`UOM_EP_N];
   logic [2:0] full_v;
   logic [2:0] in_rdy;
   logic [2:0] out_vld;
   logic [7:0] out_byte [`UOM_EP_N];

   // Bus decode. Reads take one wait state so a read right after a write sees it.
   wire take = hsel & htrans[1] & hready;
   wire rd_load = ph_rd_reg & ~rd_done_reg;
   wire sel_ok = idx_reg != 2'h0;
   wire [1:0] s = idx_reg - 2'h1;
   wire [7:0] wd = hwdata[7:0];
   wire wr_csrl = ph_wr_reg & sel_ok & (ph_idx_reg == `UOM_IDX_CSRL);
   wire wr_cfg = ph_wr_reg & sel_ok & (ph_idx_reg == `UOM_IDX_CFG);
   wire wr_sel = ph_wr_reg & (ph_idx_reg == `UOM_IDX_EPSEL);
   wire rd_data = rd_load & sel_ok & (ph_idx_reg == `UOM_IDX_DATA);
   assign hreadyout = ~rd_load;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;

   // Link side decode.
   wire [1:0] tok = rx_ep - 2'h1;
   wire tok_take = rx_token & (st_reg == uom_pkg::RX_IDLE) & (rx_ep != 2'h0);
   wire tok_stall = send_stall_reg[tok] & ~iso_reg[tok];
   wire tok_busy = full_v[tok] | (fl_busy_reg & (fl_ep_reg == tok));
   wire stall_hit = tok_take & tok_stall;
   wire in_data = st_reg == uom_pkg::RX_DATA;
   wire com = in_data & rx_end;
   wire com_err = rx_crc_err & rx_iso_reg;
   wire drop_end = (st_reg == uom_pkg::RX_DROP) & rx_end & rx_nak_reg;
   wire ovr_hit = drop_end & rx_iso_reg;
   wire byte_in = in_data & rx_valid & in_rdy[rx_ep_reg];
   wire hs_any = stall_hit | ((com | drop_end) & ~rx_iso_reg);
   wire [1:0] hs_next = stall_hit ? uom_pkg::HS_STALL : com ? uom_pkg::HS_ACK : uom_pkg::HS_NAK;
   assign rx_ready = in_data ? in_rdy[rx_ep_reg] : 1'b1;
   assign rx_toggle = tog_reg[rx_ep_reg];
   assign hs_valid = hs_valid_reg;
   assign hs_code = hs_code_reg;
   assign ep_event = {ev_reg[2], ev_reg[1], ev_reg[0]};

   // Flush drains the head packet byte by byte, then retires it.
   wire fl_start = wr_csrl & wd[`UOM_B_FLUSH] & ~fl_busy_reg & (pnum_reg[s] != 2'h0);
   wire fl_byte = fl_busy_reg & (fl_left_reg != 10'h000) & out_vld[fl_ep_reg];
   wire fl_done = fl_busy_reg & (fl_left_reg == 10'h000);

   // Register read view of the selected endpoint.
   wire [7:0] csrl_rd = {1'b0,
      stall_sent_reg[s],
      send_stall_reg[s],
      fl_busy_reg & (fl_ep_reg == s),
      iso_reg[s] & rdy_reg[s] & err0_reg[s],
      ovr_reg[s],
      full_v[s],
      rdy_reg[s]};
   wire [7:0] cfg_rd = {dbuf_reg[s], iso_reg[s], 6'h00};
   wire [7:0] cntl_rd = cnt0_reg[s][7:0];
   wire [7:0] cnth_rd = {6'h00, cnt0_reg[s][9:8]};
   wire [7:0] ep_rd = (ph_idx_reg == `UOM_IDX_CSRL) ? csrl_rd :
      (ph_idx_reg == `UOM_IDX_CFG) ? cfg_rd :
      (ph_idx_reg == `UOM_IDX_CNTL) ? cntl_rd :
      (ph_idx_reg == `UOM_IDX_CNTH) ? cnth_rd :
      (ph_idx_reg == `UOM_IDX_DATA) ? out_byte[s] : 8'h00;
   wire [7:0] rd_byte = (ph_idx_reg == `UOM_IDX_EPSEL) ? {6'h00, idx_reg} :
      sel_ok ? ep_rd : 8'h00;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ph_wr_reg <= 1'b0;
         ph_rd_reg <= 1'b0;
         rd_done_reg <= 1'b0;
         ph_idx_reg <= 6'h00;
         idx_reg <= 2'h0;
         hrdata_reg <= 32'h0000_0000;
      end else begin
         if (hready) begin
            ph_wr_reg <= take & hwrite;
            ph_rd_reg <= take & ~hwrite;
            ph_idx_reg <= haddr[7:2];
         end
         rd_done_reg <= rd_load;
         if (wr_sel) begin
            idx_reg <= wd[1:0];
         end
         if (rd_load) begin
            hrdata_reg <= {24'h00_0000, rd_byte};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_reg <= uom_pkg::RX_IDLE;
         rx_ep_reg <= 2'h0;
         rx_iso_reg <= 1'b0;
         rx_nak_reg <= 1'b0;
         rx_cnt_reg <= 10'h000;
         hs_valid_reg <= 1'b0;
         hs_code_reg <= uom_pkg::HS_ACK;
      end else begin
         hs_valid_reg <= hs_any;
         hs_code_reg <= uom_pkg::uom_hs_e'(hs_next);
         if (byte_in) begin
            rx_cnt_reg <= rx_cnt_reg + 10'h001;
         end
         case (st_reg)
            uom_pkg::RX_IDLE: begin
               if (tok_take) begin
                  rx_ep_reg <= tok;
                  rx_iso_reg <= iso_reg[tok];
                  rx_nak_reg <= ~tok_stall & tok_busy;
                  rx_cnt_reg <= 10'h000;
                  st_reg <= (tok_stall | tok_busy) ? uom_pkg::RX_DROP : uom_pkg::RX_DATA;
               end
            end
            uom_pkg::RX_DATA, uom_pkg::RX_DROP: begin
               if (rx_end) begin
                  st_reg <= uom_pkg::RX_IDLE;
               end
            end
            default: begin
               st_reg <= uom_pkg::RX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fl_busy_reg <= 1'b0;
         fl_ep_reg <= 2'h0;
         fl_left_reg <= 10'h000;
      end else if (fl_start) begin
         fl_busy_reg <= 1'b1;
         fl_ep_reg <= s;
         fl_left_reg <= cnt0_reg[s];
      end else if (fl_done) begin
         fl_busy_reg <= 1'b0;
      end else if (fl_byte) begin
         fl_left_reg <= fl_left_reg - 10'h001;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   for (genvar e = 0; e < `UOM_EP_N; e++) begin : g_ep
      wire [1:0] ei = 2'(e);
      wire is_s = sel_ok & (s == ei);
      wire wr_c = is_s & wr_csrl;
      wire wr_h = is_s & wr_cfg;
      wire fl_here = fl_busy_reg & (fl_ep_reg == ei);
      wire sw_pop = wr_c & ~wd[`UOM_B_RDY] & ~wd[`UOM_B_FLUSH] & rdy_reg[e];
      wire pop = sw_pop | (fl_done & (fl_ep_reg == ei));
      wire push = com & (rx_ep_reg == ei);
      wire [1:0] left = pnum_reg[e] - {1'b0, pop};
      wire rdy_set = ~rdy_reg[e] & (pnum_reg[e] != 2'h0) & ~fl_here;
      wire stl_set = stall_hit & (tok == ei);
      wire ovr_set = ovr_hit & (rx_ep_reg == ei);
      assign full_v[e] = pnum_reg[e] == (dbuf_reg[e] ? 2'h2 : 2'h1);

      always_ff @(posedge clk) begin
         if (sys_rst) begin
            send_stall_reg[e] <= 1'b0;
            stall_sent_reg[e] <= 1'b0;
            ovr_reg[e] <= 1'b0;
            rdy_reg[e] <= 1'b0;
            dbuf_reg[e] <= 1'b0;
            iso_reg[e] <= 1'b0;
            tog_reg[e] <= 1'b0;
            err0_reg[e] <= 1'b0;
            err1_reg[e] <= 1'b0;
            ev_reg[e] <= 1'b0;
            pnum_reg[e] <= 2'h0;
            cnt0_reg[e] <= 10'h000;
            cnt1_reg[e] <= 10'h000;
         end else begin
            pnum_reg[e] <= left + {1'b0, push};
            if (pop | (fl_start & is_s)) begin
               rdy_reg[e] <= 1'b0;
            end else if (rdy_set) begin
               rdy_reg[e] <= 1'b1;
            end
            if (pop) begin
               cnt0_reg[e] <= cnt1_reg[e];
               err0_reg[e] <= err1_reg[e];
            end
            if (push & (left == 2'h0)) begin
               cnt0_reg[e] <= rx_cnt_reg;
               err0_reg[e] <= com_err;
            end
            if (push & (left != 2'h0)) begin
               cnt1_reg[e] <= rx_cnt_reg;
               err1_reg[e] <= com_err;
            end
            stall_sent_reg[e] <= stl_set |
               (stall_sent_reg[e] & ~(wr_c & ~wd[`UOM_B_STL_SENT]));
            ovr_reg[e] <= ovr_set | (ovr_reg[e] & ~(wr_c & ~wd[`UOM_B_OVR]));
            if (wr_c) begin
               send_stall_reg[e] <= wd[`UOM_B_SEND_STL];
            end
            if (wr_c & wd[`UOM_B_CLR_TOG]) begin
               tog_reg[e] <= 1'b0;
            end else if (push) begin
               tog_reg[e] <= ~tog_reg[e];
            end
            if (wr_h) begin
               dbuf_reg[e] <= wd[`UOM_B_DBUF];
               iso_reg[e] <= wd[`UOM_B_ISO];
            end
            ev_reg[e] <= rdy_set | stl_set | ovr_set;
         end
      end

      uom_fifo #(.W(`UOM_FIFO_W), .D(`UOM_FIFO_D)) u_fifo (
         .clk(clk),
         .sys_rst(sys_rst),
         .in_valid(byte_in & (rx_ep_reg == ei)),
         .in_data(rx_data),
         .in_ready(in_rdy[e]),
         .out_valid(out_vld[e]),
         .out_data(out_byte[e]),
         .out_ready((rd_data & is_s) | (fl_byte & fl_here))
      );

      property p_rearm;
         sw_pop && (pnum_reg[e] == 2'h2) && !fl_busy_reg
            |=> !rdy_reg[e] ##1 (rdy_reg[e] && ev_reg[e]);
      endproperty
      a_rearm: assert property (p_rearm) else $error("second packet not re-armed");

      property p_err_pkt;
         push && com_err && (pnum_reg[e] == 2'h0) && !fl_busy_reg
            |=> ##1 (rdy_reg[e] && err0_reg[e] && ev_reg[e]);
      endproperty
      a_err_pkt: assert property (p_err_pkt) else $error("errored packet not queued");

      property p_stall_flag;
         stl_set |=> stall_sent_reg[e] && ev_reg[e];
      endproperty
      a_stall_flag: assert property (p_stall_flag) else $error("stall flag not set");

      property p_ovr_flag;
         ovr_set |=> ovr_reg[e] && ev_reg[e] && !hs_valid_reg;
      endproperty
      a_ovr_flag: assert property (p_ovr_flag) else $error("overrun not flagged");
   end

   wire tog_s = sel_ok & tog_reg[s];

   sequence s_stall_ans;
      hs_valid_reg && (hs_code_reg == uom_pkg::HS_STALL);
   endsequence
   sequence s_flush_run;
      fl_busy_reg ##[1:FL_MAX] !fl_busy_reg;
   endsequence

   property p_clr_tog;
      wr_csrl && wd[`UOM_B_CLR_TOG] |=> !tog_s;
   endproperty
   a_clr_tog: assert property (p_clr_tog) else $error("toggle not cleared");

   property p_csrl_rd;
      rd_load && (ph_idx_reg == `UOM_IDX_CSRL) |=> !hrdata_reg[`UOM_B_CLR_TOG];
   endproperty
   a_csrl_rd: assert property (p_csrl_rd) else $error("clear-toggle bit read as one");

   property p_stall;
      stall_hit |=> s_stall_ans ##0 (st_reg == uom_pkg::RX_DROP);
   endproperty
   a_stall: assert property (p_stall) else $error("no stall handshake");

   property p_iso_nostall;
      tok_take && iso_reg[tok] |=> !(hs_valid_reg && (hs_code_reg == uom_pkg::HS_STALL));
   endproperty
   a_iso_nostall: assert property (p_iso_nostall) else $error("stall in iso mode");

   property p_flush;
      fl_start |=> !csrl_rd[`UOM_B_RDY] ##0 s_flush_run;
   endproperty
   a_flush: assert property (p_flush) else $error("flush did not complete");

   property p_derr_clr;
      wr_csrl && rdy_reg[s] && !wd[`UOM_B_RDY] && !wd[`UOM_B_FLUSH]
         |=> !csrl_rd[`UOM_B_DERR];
   endproperty
   a_derr_clr: assert property (p_derr_clr) else $error("data error not cleared");

   property p_full_refuse;
      tok_take && full_v[tok] |=> (st_reg == uom_pkg::RX_DROP) && rx_ready;
   endproperty
   a_full_refuse: assert property (p_full_refuse) else $error("packet taken while full");

   property p_zero_bits;
      rd_load && ((ph_idx_reg == `UOM_IDX_CFG) || (ph_idx_reg == `UOM_IDX_CNTH))
         |=> (hrdata_reg[31:8] == 24'h00_0000) && !hrdata_reg[5] && !hrdata_reg[4];
   endproperty
   a_zero_bits: assert property (p_zero_bits) else $error("unused bits not zero");
endmodule

// file: uom_pkg.sv
// Types shared by the OUT endpoint block.
// Assumes nothing of its surroundings.
package uom_pkg;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_DATA = 2'b01,
      RX_DROP = 2'b10
   } uom_rx_e;
   typedef enum logic [1:0] {
      HS_ACK = 2'b01,
      HS_NAK = 2'b10,
      HS_STALL = 2'b11
   } uom_hs_e;
endpackage
